//--- logic/gpa_port.sv
// Added by the designer: the address map and the APB register port.
`timescale 1ns/1ps
`include "gpa_consts.svh"
// What this block does
// (RQ1) An enabled peripheral takes the pin from the latch; the pin stays readable.
// (RQ2) Writing the latch register acts like writing the pin value register.
// (RQ3) Latch reads return the latch; pin value reads return pin levels.
// (RQ4) An analog select bit disables that pin's digital input buffer.
// (RQ5) Eight bidirectional pins; direction bit one makes the pin an input.
// (RQ6) Direction bit zero drives the latch value onto the pin.
// (RQ7) Bit 3 is input only unless an LCD common or segment claim drives it; its direction reads one, its value read-only.
// (RQ8) Port writes read the pins, modify them, and store into the latch.
// (RQ9) Direction bits still steer the drivers on analog pins.
// (RQ10) Software should keep analog pins set as inputs.
// (RQ11) Digital reads of an analog pin return zero.
// (RQ12) Analog select never blocks a pin's digital output.
// (RQ13) Analog select bits reset to analog; software clears them for digital use.
// (RQ14) Among enabled output functions the highest priority one owns the pin; an enabled reference or clock input pin claim outranks them.
// (RQ15) Analog inputs work in analog mode; digital outputs still drive by priority.
// (RQ16) Fixed per-pin priority among segment, common, clock and timer functions, with the latch last.
// (RQ17) Pin levels pass a two-stage synchroniser before register reads.
module gpa_port (
  // Clock, reset and enable
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Port pins
  input wire logic [7:0] pin_i,
  output gpa_pkg::gpa_byte_t pin_o,
  output gpa_pkg::gpa_byte_t pin_oe_o,
  output gpa_pkg::gpa_byte_t input_buffer_en_o,
  output gpa_pkg::gpa_byte_t pin_level_o,
  // LCD segment and common drivers
  input wire logic lcd_segment_twelve_en_i,
  input wire logic lcd_segment_twelve_i,
  input wire logic lcd_segment_seven_en_i,
  input wire logic lcd_segment_seven_i,
  input wire logic lcd_common_two_en_i,
  input wire logic lcd_common_two_i,
  input wire logic lcd_common_three_en_i,
  input wire logic lcd_common_three_i,
  input wire logic lcd_segment_fifteen_en_i,
  input wire logic lcd_segment_fifteen_i,
  input wire logic lcd_segment_four_en_i,
  input wire logic lcd_segment_four_i,
  input wire logic lcd_segment_six_en_i,
  input wire logic lcd_segment_six_i,
  input wire logic lcd_segment_one_en_i,
  input wire logic lcd_segment_one_i,
  input wire logic lcd_segment_two_en_i,
  input wire logic lcd_segment_two_i,
  // Reference, clock and timer functions
  input wire logic reference_en_i,
  input wire logic timer_zero_clock_input_en_i,
  input wire logic clock_output_pin_en_i,
  input wire logic clock_output_pin_i,
  input wire logic clock_input_pin_en_i
);

  import gpa_pkg::*;

  gpa_byte_t direction_q;
  gpa_byte_t latch_q;
  gpa_byte_t analog_sel_q;
  gpa_byte_t pin_sync;
  gpa_byte_t pin_read;
  gpa_byte_t pin_d;
  gpa_byte_t pin_oe_d;
  gpa_byte_t rd_data_d;
  gpa_bus_e bus_q;
  gpa_reg_e reg_sel;
  logic rd_err_q;
  logic [31:0] prdata_q;
  logic access_done;
  logic wr_fire;

  // Maps a byte address to the register it selects.
  function automatic gpa_reg_e decode_reg(input logic [11:0] addr);
    case (addr)
      `GPA_OFS_PIN_VALUE: decode_reg = GPA_REG_PIN;
      `GPA_OFS_DIRECTION: decode_reg = GPA_REG_DIR;
      `GPA_OFS_LATCH: decode_reg = GPA_REG_LAT;
      `GPA_OFS_ANALOG_SEL: decode_reg = GPA_REG_ANS;
      `GPA_OFS_PIN_SET: decode_reg = GPA_REG_SET;
      `GPA_OFS_PIN_CLR: decode_reg = GPA_REG_CLR;
      default: decode_reg = GPA_REG_NONE;
    endcase
  endfunction

  // Resolves up to two claiming functions over a fallback; returns {drive_enable, level}.
  function automatic logic [1:0] pick_owner(
    input logic en_a,
    input logic oe_a,
    input logic d_a,
    input logic en_b,
    input logic oe_b,
    input logic d_b,
    input logic oe_dflt,
    input logic d_dflt
  );
    if (en_a) begin
      pick_owner = {oe_a, d_a};
    end else if (en_b) begin
      pick_owner = {oe_b, d_b};
    end else begin
      pick_owner = {oe_dflt, d_dflt};
    end
  endfunction

  gpa_sync u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .async_i(pin_i),
    .sync_o(pin_sync)
  ); // RQ17

  // Analog pins read as zero so the disabled buffer never leaks an undefined level.
  assign pin_read = pin_sync & ~analog_sel_q; // RQ11 RQ3
  assign input_buffer_en_o = ~analog_sel_q; // RQ4

  assign reg_sel = decode_reg(paddr);
  assign access_done = psel && penable && ce_i && (bus_q == GPA_BUS_HELD);
  assign wr_fire = access_done && pwrite && (reg_sel != GPA_REG_NONE);

  // Zero wait state once the setup cycle has captured read data.
  assign pready = psel && penable && ce_i && (bus_q == GPA_BUS_HELD);
  assign prdata = prdata_q;
  assign pslverr = pready && rd_err_q;

  always_comb begin
    rd_data_d = 8'h00;
    case (reg_sel)
      GPA_REG_PIN: rd_data_d = pin_read; // RQ3
      GPA_REG_DIR: rd_data_d = direction_q | `GPA_INPUT_ONLY_MASK; // RQ7
      GPA_REG_LAT: rd_data_d = latch_q; // RQ3
      GPA_REG_ANS: rd_data_d = analog_sel_q & `GPA_ANALOG_SEL_MASK;
      GPA_REG_SET: rd_data_d = pin_read;
      GPA_REG_CLR: rd_data_d = pin_read;
      default: rd_data_d = 8'h00;
    endcase
  end

  // Read data is captured while the request is held, so prdata comes from a flip-flop.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus_q <= GPA_BUS_IDLE;
      prdata_q <= 32'h00000000;
      rd_err_q <= 1'b0;
    end else if (ce_i) begin
      case (bus_q)
        GPA_BUS_IDLE: begin
          if (psel) begin
            bus_q <= GPA_BUS_HELD;
            prdata_q <= {24'h000000, rd_data_d};
            rd_err_q <= (reg_sel == GPA_REG_NONE);
          end
        end
        GPA_BUS_HELD: begin
          if (access_done) begin
            bus_q <= GPA_BUS_IDLE;
          end else begin
            prdata_q <= {24'h000000, rd_data_d};
            rd_err_q <= (reg_sel == GPA_REG_NONE);
          end
        end
        default: bus_q <= GPA_BUS_IDLE;
      endcase
    end
  end

  // Bit 3 has no latch driver, so its direction bit is held at input.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      direction_q <= `GPA_RST_DIRECTION;
    end else if (ce_i && wr_fire && reg_sel == GPA_REG_DIR && pstrb[0]) begin
      direction_q <= pwdata[7:0] | `GPA_INPUT_ONLY_MASK; // RQ7 RQ5
    end
  end

  // All implemented select bits come up analog.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      analog_sel_q <= `GPA_RST_ANALOG_SEL; // RQ13
    end else if (ce_i && wr_fire && reg_sel == GPA_REG_ANS && pstrb[0]) begin
      analog_sel_q <= pwdata[7:0] & `GPA_ANALOG_SEL_MASK;
    end
  end

  // Writes through the pin path start from the pins as read, not from the latch.
  // An analog pin reads zero here, so a set or clear on a neighbour can zero its latch.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      latch_q <= `GPA_RST_LATCH;
    end else if (ce_i && wr_fire) begin
      case (reg_sel)
        GPA_REG_PIN, GPA_REG_LAT: begin
          if (pstrb[0]) begin
            latch_q <= pwdata[7:0]; // RQ2
          end else begin
            latch_q <= pin_read; // RQ8
          end
        end
        GPA_REG_SET: begin
          latch_q <= pin_read | pwdata[7:0]; // RQ8
        end
        GPA_REG_CLR: begin
          latch_q <= pin_read & ~pwdata[7:0]; // RQ8
        end
        default: latch_q <= latch_q;
      endcase
    end
  end

  // Analog select does not enter the driver path; direction still gates the latch.
  always_comb begin
    logic [1:0] own;
    own = 2'b00;
    pin_d = 8'h00;
    pin_oe_d = 8'h00;
    own = pick_owner(lcd_segment_twelve_en_i, 1'b1, lcd_segment_twelve_i,
                     1'b0, 1'b0, 1'b0, ~direction_q[0], latch_q[0]); // RQ16 RQ14 RQ6
    {pin_oe_d[0], pin_d[0]} = own;
    own = pick_owner(lcd_segment_seven_en_i, 1'b1, lcd_segment_seven_i,
                     1'b0, 1'b0, 1'b0, ~direction_q[1], latch_q[1]); // RQ16
    {pin_oe_d[1], pin_d[1]} = own;
    own = pick_owner(lcd_common_two_en_i, 1'b1, lcd_common_two_i,
                     1'b0, 1'b0, 1'b0, ~direction_q[2], latch_q[2]); // RQ16
    {pin_oe_d[2], pin_d[2]} = own;
    own = pick_owner(lcd_common_three_en_i, 1'b1, lcd_common_three_i,
                     lcd_segment_fifteen_en_i, 1'b1, lcd_segment_fifteen_i,
                     1'b0, 1'b0); // RQ16 RQ7
    if (reference_en_i) begin
      own = 2'b00; // RQ14
    end
    {pin_oe_d[3], pin_d[3]} = own;
    own = pick_owner(lcd_segment_four_en_i, 1'b1, lcd_segment_four_i,
                     timer_zero_clock_input_en_i, 1'b0, 1'b0,
                     ~direction_q[4], latch_q[4]); // RQ16 RQ1
    {pin_oe_d[4], pin_d[4]} = own;
    own = pick_owner(lcd_segment_six_en_i, 1'b1, lcd_segment_six_i,
                     1'b0, 1'b0, 1'b0, ~direction_q[5], latch_q[5]); // RQ16
    {pin_oe_d[5], pin_d[5]} = own;
    own = pick_owner(clock_output_pin_en_i, 1'b1, clock_output_pin_i,
                     lcd_segment_one_en_i, 1'b1, lcd_segment_one_i,
                     ~direction_q[6], latch_q[6]); // RQ16 RQ1
    {pin_oe_d[6], pin_d[6]} = own;
    own = pick_owner(clock_input_pin_en_i, 1'b0, 1'b0,
                     lcd_segment_two_en_i, 1'b1, lcd_segment_two_i,
                     ~direction_q[7], latch_q[7]); // RQ16 RQ1
    {pin_oe_d[7], pin_d[7]} = own;
  end

  // Registered pin drive; direction controls drivers regardless of analog select.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_o <= 8'h00;
      pin_oe_o <= 8'h00;
    end else if (ce_i) begin
      pin_o <= pin_d; // RQ12 RQ15
      pin_oe_o <= pin_oe_d; // RQ9 RQ5
    end
  end

  // Peripherals keep seeing the pin level even while they own the pin.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_level_o <= 8'h00;
    end else if (ce_i) begin
      pin_level_o <= pin_read; // RQ1
    end
  end

endmodule

//--- shared/gpa_consts.svh
`ifndef GPA_CONSTS_SVH
`define GPA_CONSTS_SVH

// Register byte offsets on the APB bus.
`define GPA_OFS_PIN_VALUE 12'h000
`define GPA_OFS_DIRECTION 12'h004
`define GPA_OFS_LATCH 12'h008
`define GPA_OFS_ANALOG_SEL 12'h00C
`define GPA_OFS_PIN_SET 12'h010
`define GPA_OFS_PIN_CLR 12'h014

// Reset values.
`define GPA_RST_DIRECTION 8'hFF
`define GPA_RST_LATCH 8'h00
`define GPA_RST_ANALOG_SEL 8'h2F

// Field layout.
`define GPA_ANALOG_SEL_MASK 8'h2F
`define GPA_INPUT_ONLY_BIT 3
`define GPA_INPUT_ONLY_MASK 8'h08
`define GPA_PORT_WIDTH 8

`endif

//--- shared/gpa_pkg.sv
package gpa_pkg;

  typedef logic [7:0] gpa_byte_t;

  typedef enum logic [2:0] {
    GPA_REG_PIN,
    GPA_REG_DIR,
    GPA_REG_LAT,
    GPA_REG_ANS,
    GPA_REG_SET,
    GPA_REG_CLR,
    GPA_REG_NONE
  } gpa_reg_e;

  typedef enum logic [0:0] {
    GPA_BUS_IDLE,
    GPA_BUS_HELD
  } gpa_bus_e;

endpackage

//--- logic/gpa_sync.sv
`timescale 1ns/1ps
module gpa_sync (
  // Clock, reset and enable
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Asynchronous levels in, synchronised levels out
  input wire logic [7:0] async_i,
  output logic [7:0] sync_o
);

  logic [7:0] stage1_q;
  logic [7:0] stage2_q;

  // The first stage feeds only the second one, so a metastable bit never fans out.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stage1_q <= 8'h00;
      stage2_q <= 8'h00;
    end else if (ce_i) begin
      stage1_q <= async_i;
      stage2_q <= stage1_q;
    end
  end

  assign sync_o = stage2_q;

endmodule

//--- test/gpa_port_properties.sv
`timescale 1ns/1ps
module gpa_port_chk (
  // Clock and bus
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Pins and claims
  input wire gpa_pkg::gpa_byte_t pin_o,
  input wire gpa_pkg::gpa_byte_t pin_oe_o,
  input wire gpa_pkg::gpa_byte_t input_buffer_en_o,
  input wire gpa_pkg::gpa_byte_t pin_level_o,
  input wire logic lcd_segment_twelve_en_i,
  input wire logic lcd_segment_twelve_i,
  input wire logic clock_output_pin_en_i,
  input wire logic clock_output_pin_i,
  input wire logic clock_input_pin_en_i,
  input wire logic reference_en_i,
  input wire logic lcd_common_three_en_i,
  input wire logic lcd_segment_fifteen_en_i
);
  import gpa_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("error flag without ready");
  chk_frozen_idle: assert property (!ce_i |-> !pready)
    else $error("ready while frozen");
  chk_zero_wait: assert property ($past(psel) && !$past(penable) && $past(ce_i)
    && psel && penable && ce_i |-> pready) else $error("access not answered at once");
  chk_seg_twelve: assert property (ce_i && lcd_segment_twelve_en_i
    |=> pin_oe_o[0] && pin_o[0] == $past(lcd_segment_twelve_i)) else $error("bit 0 claim lost");
  chk_clock_output_pin_wins: assert property (ce_i && clock_output_pin_en_i
    |=> pin_oe_o[6] && pin_o[6] == $past(clock_output_pin_i)) else $error("bit 6 claim lost");
  chk_clock_input_pin_off: assert property (ce_i && clock_input_pin_en_i |=> !pin_oe_o[7])
    else $error("bit 7 driven under input claim");
  chk_ref_off: assert property (ce_i && reference_en_i |=> !pin_oe_o[3])
    else $error("bit 3 driven under reference");
  chk_bit3_input: assert property (ce_i && !lcd_common_three_en_i && !lcd_segment_fifteen_en_i
    |=> !pin_oe_o[3]) else $error("bit 3 driven by latch");
  chk_analog_zero: assert property ((pin_level_o & ~$past(input_buffer_en_o)) == 8'h00)
    else $error("analog pin reads one");
  chk_ibuf_fixed: assert property ((input_buffer_en_o & 8'hD0) == 8'hD0)
    else $error("buffer off on a digital only pin");
endmodule

bind gpa_port gpa_port_chk u_chk (.*);

//--- test/gpa_pins_model.sv
`timescale 1ns/1ps
module gpa_pins_model (
  // Block side
  input wire gpa_pkg::gpa_byte_t pin_o,
  input wire gpa_pkg::gpa_byte_t pin_oe_o,
  // Outside circuit
  input wire logic [7:0] ext_i,
  output logic [7:0] pin_i
);
  import gpa_pkg::*;
  // The outside circuit is a weak source, so a driven pin always shows the block's level.
  assign pin_i = (pin_oe_o & pin_o) | (~pin_oe_o & ext_i);
endmodule

//--- test/gpa_port_bench.sv
`timescale 1ns/1ps
`include "gpa_consts.svh"
`define CK(g, e) begin checked++; if ((g) !== (e)) begin fail_count++; \
  $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module gpa_port_bench;
  import gpa_pkg::*;
  logic clk_i = 0, rst_n_i = 0, ce_i = 1, psel = 0, penable = 0, pwrite = 0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr;
  logic [22:0] fx = 23'h0;
  gpa_byte_t pin_o, pin_oe_o, pins, ext = 8'h00, r, v, d, a, w;
  int seed = 32'h3DF7AC5F, fail_count = 0, checked = 0, cyc = 0;
  gpa_port dut (.*, .pin_i(pins), .input_buffer_en_o(), .pin_level_o(),
    .lcd_segment_twelve_en_i(fx[0]), .lcd_segment_twelve_i(fx[1]),
    .lcd_segment_seven_en_i(fx[2]), .lcd_segment_seven_i(fx[3]),
    .lcd_common_two_en_i(fx[4]), .lcd_common_two_i(fx[5]),
    .lcd_common_three_en_i(fx[6]), .lcd_common_three_i(fx[7]),
    .lcd_segment_fifteen_en_i(fx[8]), .lcd_segment_fifteen_i(fx[9]),
    .lcd_segment_four_en_i(fx[10]), .lcd_segment_four_i(fx[11]),
    .lcd_segment_six_en_i(fx[12]), .lcd_segment_six_i(fx[13]),
    .lcd_segment_one_en_i(fx[14]), .lcd_segment_one_i(fx[15]),
    .lcd_segment_two_en_i(fx[16]), .lcd_segment_two_i(fx[17]),
    .reference_en_i(fx[18]), .timer_zero_clock_input_en_i(fx[19]),
    .clock_output_pin_en_i(fx[20]), .clock_output_pin_i(fx[21]),
    .clock_input_pin_en_i(fx[22]));
  gpa_pins_model pm (.pin_o(pin_o), .pin_oe_o(pin_oe_o), .ext_i(ext), .pin_i(pins));
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  // Bit 3 is never driven from the latch, so it follows the outside circuit unless selected analog.
  function automatic gpa_byte_t pin_exp(gpa_byte_t l, gpa_byte_t dd, gpa_byte_t x, gpa_byte_t an);
    gpa_byte_t oe;
    oe = ~dd & 8'hF7;
    return ((l & oe) | (x & ~oe)) & ~an;
  endfunction
  // Expected drivers with every direction bit at output; bit 3 drives only under an LCD claim, elsewhere only claims turn a driver off.
  function automatic gpa_byte_t oe_exp(logic [22:0] f);
    gpa_byte_t e;
    e = 8'hF7;
    e[3] = !f[18] && (f[6] || f[8]);
    e[4] = f[10] || !f[19];
    e[7] = !f[22];
    return e;
  endfunction
  task automatic wrap_up();
    if (fail_count == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] ad, input gpa_byte_t dt);
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= {24'h000000, dt};
    @(posedge clk_i);
    penable <= 1'b1;
    do @(posedge clk_i); while (pready !== 1'b1);
    err = pslverr;
    r = prdata[7:0];
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc > 5000) begin
      fail_count++;
      wrap_up();
    end
  end
  initial begin
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    apb(0, `GPA_OFS_DIRECTION, 8'h00); `CK(r, 8'hFF)
    apb(0, `GPA_OFS_ANALOG_SEL, 8'h00); `CK(r, 8'h2F)
    apb(0, `GPA_OFS_LATCH, 8'h00); `CK(r, `GPA_RST_LATCH)
    apb(1, `GPA_OFS_ANALOG_SEL, 8'h00);
    for (int i = 0; i < 8; i++) begin
      v = $random(seed);
      d = $random(seed);
      ext <= $random(seed);
      apb(1, i[0] ? `GPA_OFS_PIN_VALUE : `GPA_OFS_LATCH, v);
      apb(1, `GPA_OFS_DIRECTION, d);
      apb(0, `GPA_OFS_LATCH, 8'h00); `CK(r, v)
      apb(0, `GPA_OFS_DIRECTION, 8'h00); `CK(r, d | 8'h08)
      repeat (4) @(posedge clk_i);
      `CK(pin_oe_o, ~d & 8'hF7)
      `CK(pin_o & ~d & 8'hF7, v & ~d & 8'hF7)
      apb(0, `GPA_OFS_PIN_VALUE, 8'h00); `CK(r, pin_exp(v, d, ext, 8'h00))
    end
    for (int k = 0; k < 2; k++) begin
      a = k ? 8'h2F : 8'h00;
      w = $random(seed);
      ext <= $random(seed);
      apb(1, `GPA_OFS_ANALOG_SEL, a);
      apb(1, `GPA_OFS_DIRECTION, 8'hFF);
      repeat (4) @(posedge clk_i);
      apb(1, `GPA_OFS_PIN_SET, w);
      apb(0, `GPA_OFS_LATCH, 8'h00); `CK(r, (ext & ~a) | w)
      apb(1, `GPA_OFS_PIN_CLR, w);
      apb(0, `GPA_OFS_LATCH, 8'h00); `CK(r, ext & ~a & ~w)
      v = r;
      apb(1, `GPA_OFS_DIRECTION, 8'h00);
      repeat (4) @(posedge clk_i);
      `CK(pin_oe_o, 8'hF7)
      apb(0, `GPA_OFS_PIN_VALUE, 8'h00); `CK(r, pin_exp(v, 8'h00, ext, a))
    end
    apb(0, 12'h018, 8'h00); `CK(err, 1'b1)
    `CK(r, 8'h00)
    ce_i <= 1'b0;
    fork
      apb(0, `GPA_OFS_DIRECTION, 8'h00);
      begin
        repeat (3) @(posedge clk_i);
        ce_i <= 1'b1;
      end
    join
    `CK(r, 8'h08)
    repeat (60) begin
      @(posedge clk_i);
      fx <= 23'($random(seed));
      repeat (2) @(posedge clk_i);
      `CK(pin_oe_o, oe_exp(fx))
    end
    wrap_up();
  end
endmodule
